// ===== src/serial_irq_pkg.sv
// Overview of operation
// - start frame lasts 4, 6 or 8 clocks by two-bit field; 11 reserved, reset 4
// - polling bit: 0 runs continuous streams, 1 runs quiet streams
// - slot recovery phase: bit 0 drives line high, bit 1 leaves it undriven; start and stop recovery always driven
// - each of sixteen slots has a bit: 0 edge handling, 1 level handling
// - level slot seen asserted on the stream sets its status bit
// - software writes 1 to a status bit to clear and re-arm it
// - edge-handled slots never set a status bit
// - mode control bits 7:4 read zero and ignore writes
// - all fields reset on link reset, global reset and power-on reset
// - status bits 13 to 0 behave like bits 15 and 14
package serial_irq_pkg;
    localparam int          NUM_SLOTS          = 16;
    localparam logic [7:0]  MODE_CTRL_OFFSET   = 8'hE0;
    localparam logic [7:0]  EDGE_SEL_OFFSET    = 8'hE2;
    localparam logic [7:0]  STATUS_OFFSET      = 8'hE4;
    localparam logic [5:0]  DWORD_MODE_EDGE    = 6'h38;
    localparam logic [5:0]  DWORD_STATUS       = 6'h39;
    localparam logic [7:0]  MODE_CTRL_RESET    = 8'h00;
    localparam logic [15:0] EDGE_SEL_RESET     = 16'h0000;
    localparam logic [15:0] STATUS_RESET       = 16'h0000;
    localparam logic [7:0]  MODE_WRITE_MASK    = 8'h0F;
    localparam int          START_WIDTH_LSB    = 2;
    localparam int          POLL_BIT           = 1;
    localparam int          DRIVE_BIT          = 0;
    localparam logic [1:0]  WIDTH_4            = 2'h0;
    localparam logic [1:0]  WIDTH_6            = 2'h1;
    localparam logic [1:0]  WIDTH_8            = 2'h2;
    localparam logic [3:0]  START_CLOCKS_4     = 4'h4;
    localparam logic [3:0]  START_CLOCKS_6     = 4'h6;
    localparam logic [3:0]  START_CLOCKS_8     = 4'h8;
    localparam logic [3:0]  STOP_CLOCKS_CONT   = 4'h3;
    localparam logic [3:0]  STOP_CLOCKS_QUIET  = 4'h2;
    localparam logic [3:0]  IDLE_GAP_CLOCKS    = 4'h2;
    localparam int          SYNC_LATENCY       = 2;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_START     = 4'h1,
        ST_START_REC = 4'h2,
        ST_START_TAR = 4'h3,
        ST_SAMPLE    = 4'h4,
        ST_SLOT_REC  = 4'h5,
        ST_SLOT_TAR  = 4'h6,
        ST_STOP      = 4'h7,
        ST_STOP_REC  = 4'h8,
        ST_STOP_TAR  = 4'h9,
        ST_GAP       = 4'hA
    } stream_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  dword;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic oe;
        logic level;
    } line_drive_s;
endpackage

// ===== src/serial_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module serial_irq_ctrl
    import serial_irq_pkg::*;
(
    // clock and resets
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        LINK_RESET_N_IN,
    input  wire logic        GLOBAL_RESET_N_IN,
    // configuration space access
    input  wire logic        CFG_WR_IN,
    input  wire logic        CFG_RD_IN,
    input  wire logic [5:0]  CFG_DWORD_IN,
    input  wire logic [3:0]  CFG_BE_IN,
    input  wire logic [31:0] CFG_WDATA_IN,
    output logic      [31:0] CFG_RDATA_OUT,
    output logic             CFG_RD_VALID_OUT,
    // serial interrupt line
    input  wire logic        SERIAL_INTERRUPT_LINE_IN,
    output logic             SERIAL_INTERRUPT_LINE_OUT,
    output logic             SERIAL_INTERRUPT_LINE_OE_OUT,
    // decoded slot levels
    output logic      [15:0] SLOT_ASSERTED_OUT
);
    // any of the three resets clears everything
    logic rst_n;
    assign rst_n = RESET_N_IN & LINK_RESET_N_IN & GLOBAL_RESET_N_IN;

    cfg_req_s req;
    assign req = '{wr: CFG_WR_IN, rd: CFG_RD_IN, dword: CFG_DWORD_IN, be: CFG_BE_IN, wdata: CFG_WDATA_IN};

    function automatic logic [3:0] start_clocks(input logic [1:0] sel);
        // reserved code falls back to the narrowest pulse
        case (sel)
            WIDTH_6: start_clocks = START_CLOCKS_6;
            WIDTH_8: start_clocks = START_CLOCKS_8;
            default: start_clocks = START_CLOCKS_4;
        endcase
    endfunction

    function automatic line_drive_s drive_of(input stream_state_e st, input logic tristate_rec);
        drive_of = '{oe: 1'b0, level: 1'b1};
        case (st)
            ST_START, ST_STOP:          drive_of = '{oe: 1'b1, level: 1'b0};
            ST_START_REC, ST_STOP_REC:  drive_of = '{oe: 1'b1, level: 1'b1};
            ST_SLOT_REC:                drive_of = '{oe: ~tristate_rec, level: 1'b1};
            default:                    drive_of = '{oe: 1'b0, level: 1'b1};
        endcase
    endfunction

    // registers
    logic [7:0]  mode_ctrl;
    logic [15:0] edge_sel;
    logic [15:0] status;
    logic [7:0]  next_mode_ctrl;
    logic [15:0] next_edge_sel;
    logic [15:0] next_status;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        rd_valid;
    logic        next_rd_valid;

    // stream engine
    stream_state_e state;
    stream_state_e next_state;
    logic [3:0]    cnt;
    logic [3:0]    next_cnt;
    logic [3:0]    slot;
    logic [3:0]    next_slot;
    line_drive_s   drive;
    line_drive_s   next_drive;
    logic [15:0]   asserted;
    logic [15:0]   next_asserted;

    // two-flop synchroniser and sample pipeline matching its delay
    logic                    line_meta;
    logic                    line_sync;
    logic [SYNC_LATENCY-1:0] samp_pipe;
    logic [SYNC_LATENCY-1:0] next_samp_pipe;
    logic [3:0]              samp_slot [SYNC_LATENCY];
    logic [3:0]              next_samp_slot [SYNC_LATENCY];

    logic       tristate_rec;
    logic       quiet;
    logic [1:0] width_sel;
    logic       samp_now;
    logic [3:0] samp_idx;
    logic       slot_low;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;

    assign tristate_rec = mode_ctrl[DRIVE_BIT];
    assign quiet        = mode_ctrl[POLL_BIT];
    assign width_sel    = mode_ctrl[START_WIDTH_LSB+1:START_WIDTH_LSB];
    assign samp_now     = samp_pipe[SYNC_LATENCY-1];
    assign samp_idx     = samp_slot[SYNC_LATENCY-1];
    assign slot_low     = samp_now & ~line_sync;

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
        end else begin
            line_meta <= SERIAL_INTERRUPT_LINE_IN;
            line_sync <= line_meta;
        end
    end

    // stream sequencing
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_slot  = slot;
        unique case (state)
            ST_IDLE: begin
                // continuous streams start on their own; quiet waits for a request
                if (!quiet || !line_sync) begin
                    next_state = ST_START;
                    next_cnt   = start_clocks(width_sel) - 4'h1;
                end
            end
            ST_START: begin
                // count was loaded with width minus one, so zero ends the pulse
                if (cnt == 4'h0) begin
                    next_state = ST_START_REC;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_START_REC: next_state = ST_START_TAR;
            ST_START_TAR: begin
                next_state = ST_SAMPLE;
                next_slot  = 4'h0;
            end
            ST_SAMPLE:    next_state = ST_SLOT_REC;
            ST_SLOT_REC:  next_state = ST_SLOT_TAR;
            ST_SLOT_TAR: begin
                if (slot == 4'(NUM_SLOTS - 1)) begin
                    next_state = ST_STOP;
                    next_cnt   = (quiet ? STOP_CLOCKS_QUIET : STOP_CLOCKS_CONT) - 4'h1;
                end else begin
                    next_state = ST_SAMPLE;
                    next_slot  = slot + 4'h1;
                end
            end
            ST_STOP: begin
                if (cnt == 4'h0) begin
                    next_state = ST_STOP_REC;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_STOP_REC:  next_state = ST_STOP_TAR;
            ST_STOP_TAR: begin
                next_state = ST_GAP;
                next_cnt   = IDLE_GAP_CLOCKS;
            end
            ST_GAP: begin
                // short idle lets the line settle before a new request is read
                if (cnt == 4'h0) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_drive = drive_of(next_state, tristate_rec);
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt   <= 4'h0;
            slot  <= 4'h0;
            drive <= '{oe: 1'b0, level: 1'b1};
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            slot  <= next_slot;
            drive <= next_drive;
        end
    end

    // sample pipeline: a slot's level reaches line_sync two clocks late
    always_comb begin
        next_samp_pipe    = {samp_pipe[SYNC_LATENCY-2:0], (state == ST_SAMPLE)};
        next_samp_slot[0] = slot;
        for (int i = 1; i < SYNC_LATENCY; i++) begin
            next_samp_slot[i] = samp_slot[i-1];
        end
        next_asserted = asserted;
        if (samp_now) begin
            next_asserted[samp_idx] = ~line_sync;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            samp_pipe <= '0;
            asserted  <= 16'h0000;
            for (int i = 0; i < SYNC_LATENCY; i++) begin
                samp_slot[i] <= 4'h0;
            end
        end else begin
            samp_pipe <= next_samp_pipe;
            asserted  <= next_asserted;
            for (int i = 0; i < SYNC_LATENCY; i++) begin
                samp_slot[i] <= next_samp_slot[i];
            end
        end
    end

    // level slot flags, set beats a simultaneous write-one clear
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_flag
            assign set_vec[g] = slot_low && (samp_idx == 4'(g)) && edge_sel[g];
        end
    endgenerate

    always_comb begin
        next_mode_ctrl = mode_ctrl;
        next_edge_sel  = edge_sel;
        clr_vec        = 16'h0000;
        next_rd_valid  = req.rd;
        next_rdata     = 32'h0000_0000;
        if (req.wr && req.dword == DWORD_MODE_EDGE) begin
            if (req.be[0]) begin
                next_mode_ctrl = req.wdata[7:0] & MODE_WRITE_MASK;
            end
            if (req.be[2]) begin
                next_edge_sel[7:0] = req.wdata[23:16];
            end
            if (req.be[3]) begin
                next_edge_sel[15:8] = req.wdata[31:24];
            end
        end
        if (req.wr && req.dword == DWORD_STATUS) begin
            if (req.be[0]) begin
                clr_vec[7:0] = req.wdata[7:0];
            end
            if (req.be[1]) begin
                clr_vec[15:8] = req.wdata[15:8];
            end
        end
        next_status = (status & ~clr_vec) | set_vec;
        if (req.rd) begin
            if (req.dword == DWORD_MODE_EDGE) begin
                next_rdata = {edge_sel, 8'h00, mode_ctrl};
            end else if (req.dword == DWORD_STATUS) begin
                next_rdata = {16'h0000, status};
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            mode_ctrl <= MODE_CTRL_RESET;
            edge_sel  <= EDGE_SEL_RESET;
            status    <= STATUS_RESET;
            rdata     <= 32'h0000_0000;
            rd_valid  <= 1'b0;
        end else begin
            mode_ctrl <= next_mode_ctrl;
            edge_sel  <= next_edge_sel;
            status    <= next_status;
            rdata     <= next_rdata;
            rd_valid  <= next_rd_valid;
        end
    end

    assign CFG_RDATA_OUT                = rdata;
    assign CFG_RD_VALID_OUT             = rd_valid;
    assign SERIAL_INTERRUPT_LINE_OUT    = drive.level;
    assign SERIAL_INTERRUPT_LINE_OE_OUT = drive.oe;
    assign SLOT_ASSERTED_OUT            = asserted;
endmodule
`default_nettype wire

// ===== sim/serial_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module serial_irq_checker
    import serial_irq_pkg::*;
(
    // clock and resets
    input wire logic        CORE_CLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        LINK_RESET_N_IN,
    input wire logic        GLOBAL_RESET_N_IN,
    // config port
    input wire logic        CFG_WR_IN,
    input wire logic        CFG_RD_IN,
    input wire logic [5:0]  CFG_DWORD_IN,
    input wire logic [3:0]  CFG_BE_IN,
    input wire logic [31:0] CFG_WDATA_IN,
    input wire logic [31:0] CFG_RDATA_OUT,
    input wire logic        CFG_RD_VALID_OUT,
    // line side
    input wire logic        SERIAL_INTERRUPT_LINE_OUT,
    input wire logic        SERIAL_INTERRUPT_LINE_OE_OUT,
    input wire logic [15:0] SLOT_ASSERTED_OUT
);
    wire logic rst_ok = RESET_N_IN & LINK_RESET_N_IN & GLOBAL_RESET_N_IN;
    wire logic drv_lo = SERIAL_INTERRUPT_LINE_OE_OUT & ~SERIAL_INTERRUPT_LINE_OUT;
    wire logic drv_hi = SERIAL_INTERRUPT_LINE_OE_OUT & SERIAL_INTERRUPT_LINE_OUT;
    wire logic cfg_wr = CFG_WR_IN & (CFG_DWORD_IN == DWORD_MODE_EDGE);
    logic [3:0]  mode;
    logic [15:0] lvl;
    logic [3:0]  run;
    // reserved width code reads as the shortest frame
    wire logic [3:0] w = (mode[3:2] == 2'h1) ? 4'h6 : (mode[3:2] == 2'h2) ? 4'h8 : 4'h4;
    always_ff @(posedge CORE_CLK_IN or negedge rst_ok) begin
        if (!rst_ok) begin
            mode <= 4'h0;
            lvl <= 16'h0000;
            run <= 4'h0;
        end else begin
            if (cfg_wr && CFG_BE_IN[0]) mode <= CFG_WDATA_IN[3:0];
            if (cfg_wr && CFG_BE_IN[2]) lvl[7:0] <= CFG_WDATA_IN[23:16];
            if (cfg_wr && CFG_BE_IN[3]) lvl[15:8] <= CFG_WDATA_IN[31:24];
            run <= drv_lo ? run + 4'h1 : 4'h0;
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!rst_ok);
    read_answer_a: assert property (CFG_RD_IN |=> CFG_RD_VALID_OUT) else $error("read not answered");
    idle_data_a: assert property (!CFG_RD_VALID_OUT |-> CFG_RDATA_OUT == 32'h0000_0000)
        else $error("data outside answer");
    mode_read_a: assert property (CFG_RD_VALID_OUT && $past(CFG_DWORD_IN) == DWORD_MODE_EDGE
        |-> CFG_RDATA_OUT == {$past(lvl), 12'h000, $past(mode)}) else $error("mode read wrong");
    edge_quiet_a: assert property (CFG_RD_VALID_OUT && $past(CFG_DWORD_IN) == DWORD_STATUS
        |-> CFG_RDATA_OUT[31:16] == 16'h0000 && (CFG_RDATA_OUT[15:0] & ~$past(lvl)) == 16'h0000)
        else $error("edge slot flagged");
    start_width_a: assert property (!drv_lo && run != 4'h0
        |-> run == w || run == STOP_CLOCKS_CONT || run == STOP_CLOCKS_QUIET) else $error("bad frame width");
    recovery_one_a: assert property (drv_hi |=> !SERIAL_INTERRUPT_LINE_OE_OUT)
        else $error("recovery too long");
    tristate_rec_a: assert property (drv_hi && mode[0] && $past(mode[0]) |-> $past(drv_lo))
        else $error("slot recovery driven");
    reset_values_a: assert property ($rose(rst_ok)
        |-> !SERIAL_INTERRUPT_LINE_OE_OUT && !CFG_RD_VALID_OUT && SLOT_ASSERTED_OUT == 16'h0000)
        else $error("not reset");
endmodule
`default_nettype wire

// ===== sim/serial_irq_peripheral.sv
`timescale 1ns/1ps
`default_nettype none
module serial_irq_peripheral (
    input  wire logic        clk_in,
    input  wire logic        line_in,
    input  wire logic [15:0] mask_in,
    input  wire logic        req_in,
    output logic             pull_low_out = 1'b0
);
    int run = 0;
    int pos = -1;
    // position comes from the wire alone, as a real peripheral sees it
    always_ff @(posedge clk_in) begin
        run <= line_in ? 0 : run + 1;
        if (line_in && run >= 4) pos <= 0;
        else if (pos >= 0 && pos < 60) pos <= pos + 1;
        else pos <= -1;
        pull_low_out <= req_in || (pos >= 0 && pos < 48 && pos % 3 == 0 && mask_in[pos / 3]);
    end
endmodule
`default_nettype wire

// ===== sim/serial_irq_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_irq_ctrl_bench
    import serial_irq_pkg::*;
;
    logic        clk = 1'b0;
    logic        por_n = 1'b0;
    logic        link_n = 1'b1;
    logic        glob_n = 1'b1;
    logic        ireq = 1'b0;
    logic [15:0] mask = 16'h0000;
    cfg_req_s    cfg = '0;
    logic [31:0] rdata;
    logic [15:0] slots;
    logic        rd_valid, line_out, line_oe, pull_low;
    int          err_count = 0;
    int          samples_checked = 0;
    // pull-up wins when nobody drives
    wire logic   line = (line_oe ? line_out : 1'b1) & ~pull_low;
    always #12.5 clk = ~clk;
    serial_irq_ctrl dut (.CORE_CLK_IN(clk), .RESET_N_IN(por_n), .LINK_RESET_N_IN(link_n),
        .GLOBAL_RESET_N_IN(glob_n), .CFG_WR_IN(cfg.wr), .CFG_RD_IN(cfg.rd), .CFG_DWORD_IN(cfg.dword),
        .CFG_BE_IN(cfg.be), .CFG_WDATA_IN(cfg.wdata), .CFG_RDATA_OUT(rdata), .CFG_RD_VALID_OUT(rd_valid),
        .SERIAL_INTERRUPT_LINE_IN(line), .SERIAL_INTERRUPT_LINE_OUT(line_out),
        .SERIAL_INTERRUPT_LINE_OE_OUT(line_oe), .SLOT_ASSERTED_OUT(slots));
    serial_irq_peripheral peri (.clk_in(clk), .line_in(line), .mask_in(mask), .req_in(ireq),
        .pull_low_out(pull_low));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [5:0] dw, logic [3:0] be, logic [31:0] d);
        @(negedge clk);
        cfg = '{1'b1, 1'b0, dw, be, d};
        @(negedge clk);
        cfg.wr = 1'b0;
    endtask
    task automatic rd_chk(string name, logic [5:0] dw, logic [31:0] exp);
        @(negedge clk);
        cfg = '{1'b0, 1'b1, dw, 4'h0, 32'h0000_0000};
        @(negedge clk);
        cfg.rd = 1'b0;
        check(name, rdata, exp);
    endtask
    // bounded wait for a device low drive, then its length
    task automatic low_run(output int n);
        n = 0;
        for (int i = 0; i < 300 && !(line_oe && !line_out); i++) @(negedge clk);
        while (line_oe && !line_out && n < 20) begin
            n++;
            @(negedge clk);
        end
    endtask
    task automatic frame(output int n);
        // a request during the gap after a stop is ignored, so let the engine reach idle
        repeat (8) @(negedge clk);
        ireq = 1'b1;
        @(negedge clk);
        ireq = 1'b0;
        low_run(n);
    endtask
    task automatic t_regs();
        rd_chk("mode_reset", DWORD_MODE_EDGE, 32'h0000_0000);
        rd_chk("status_reset", DWORD_STATUS, 32'h0000_0000);
        wr(DWORD_MODE_EDGE, 4'hF, 32'hFFFF_FFF2);
        rd_chk("mode_rsvd", DWORD_MODE_EDGE, 32'hFFFF_0002);
        rd_chk("unmapped", 6'h00, 32'h0000_0000);
        wr(DWORD_MODE_EDGE, 4'hC, 32'h8001_0000);
        rd_chk("level_sel", DWORD_MODE_EDGE, 32'h8001_0002);
    endtask
    task automatic t_width();
        int n;
        int busy = 0;
        repeat (100) @(negedge clk);
        repeat (100) begin
            @(negedge clk);
            busy += line_oe;
        end
        check("quiet_idle", busy, 0);
        for (int w = 0; w < 4; w++) begin
            wr(DWORD_MODE_EDGE, 4'h1, {28'h0, w[1:0], 2'b10});
            frame(n);
            check("start_width", n, (w == 3) ? 4 : 4 + 2 * w);
            low_run(n);
            check("stop_quiet", n, 32'(STOP_CLOCKS_QUIET));
        end
    endtask
    task automatic t_status();
        int n;
        mask = 16'hC003;
        frame(n);
        low_run(n);
        repeat (8) @(negedge clk);
        check("slots_seen", slots, 16'hC003);
        rd_chk("status_level", DWORD_STATUS, 32'h0000_8001);
        mask = 16'h0000;
        wr(DWORD_STATUS, 4'h3, 32'h0000_0001);
        rd_chk("status_w1c", DWORD_STATUS, 32'h0000_8000);
        mask = 16'h0001;
        frame(n);
        low_run(n);
        repeat (8) @(negedge clk);
        rd_chk("status_rearm", DWORD_STATUS, 32'h0000_8001);
    endtask
    task automatic t_drive(logic tri_st, int exp);
        int n = 0;
        int hi = 0;
        wr(DWORD_MODE_EDGE, 4'h1, {31'h0, tri_st});
        for (int i = 0; i < 4 && n != 4; i++) low_run(n);
        while (!(line_oe && !line_out) && hi < 100) begin
            hi += line_oe;
            @(negedge clk);
        end
        check("recovery_drive", hi, exp);
        low_run(n);
        check("stop_cont", n, 32'(STOP_CLOCKS_CONT));
    endtask
    task automatic t_reset();
        for (int k = 0; k < 3; k++) begin
            wr(DWORD_MODE_EDGE, 4'hF, 32'h0001_000D);
            {por_n, link_n, glob_n} = ~(3'b100 >> k);
            @(negedge clk);
            {por_n, link_n, glob_n} = 3'b111;
            rd_chk("mode_after_reset", DWORD_MODE_EDGE, 32'h0000_0000);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        por_n = 1'b1;
        t_regs();
        t_width();
        t_status();
        t_drive(1'b0, 17);
        t_drive(1'b1, 1);
        t_reset();
        results();
    end
    // whole run is about a thousand cycles
    initial begin
        #500000;
        err_count++;
        results();
    end
endmodule
bind serial_irq_ctrl serial_irq_checker chk (.CORE_CLK_IN, .RESET_N_IN, .LINK_RESET_N_IN, .GLOBAL_RESET_N_IN,
    .CFG_WR_IN, .CFG_RD_IN, .CFG_DWORD_IN, .CFG_BE_IN, .CFG_WDATA_IN, .CFG_RDATA_OUT, .CFG_RD_VALID_OUT,
    .SERIAL_INTERRUPT_LINE_OUT, .SERIAL_INTERRUPT_LINE_OE_OUT, .SLOT_ASSERTED_OUT);
`default_nettype wire
